// ===== hdl/dtu_responder.sv
// Serial responder for the discovery table and the unique identifier
`timescale 1ns/100ps
`include "dtu_consts.svh"
module dtu_responder import dtu_pkg::*; #(
    parameter int POWERUP_CYCLES = `DTU_POWERUP_CYC,
    // Arbitrary per-die identifier value for simulation
    parameter logic [95:0] DIE_ID = 96'h0123456789ABCDEF01234567
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe_n,
    output logic ready
);
    dtu_link_in_s sync1_q;
    dtu_link_in_s sync2_q;
    logic sclk_prev_q;
    dtu_state_e state_q;
    dtu_src_e src_q;
    logic [2:0] bitcnt_q;
    logic [1:0] addr_bytes_q;
    logic [7:0] shift_in_q;
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic [7:0] out_q;
    logic [15:0] pu_cnt_q;
    logic rise;
    logic fall;
    logic [7:0] rx_byte;
    logic [7:0] tbl_byte;
    logic [7:0] uid_byte;
    logic [7:0] data_byte;
    logic [3:0] uid_idx;
    logic pu_done;

    // Link pins cross into core_clk through two flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_q <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            sync2_q <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
        end else begin
            sync1_q <= '{sclk: sclk, cs_n: cs_n, mosi: mosi};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sync2_q.sclk;
        end
    end

    assign rise = sync2_q.sclk & ~sclk_prev_q & ~sync2_q.cs_n;
    assign fall = ~sync2_q.sclk & sclk_prev_q & ~sync2_q.cs_n;
    assign rx_byte = {shift_in_q[6:0], sync2_q.mosi};

    // Commands arriving before the power-up wait are ignored
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pu_cnt_q <= '0;
        end else if (!pu_done) begin
            pu_cnt_q <= pu_cnt_q + 16'h0001;
        end
    end
    assign pu_done = (32'(pu_cnt_q) >= POWERUP_CYCLES);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ready <= 1'b0;
        end else begin
            ready <= pu_done;
        end
    end

    // Table contents for the upper parameter dwords
    always_comb begin
        unique case (addr_q)
            8'h40: tbl_byte = `DTU_TBL_CAPS;
            8'h41, 8'h42, 8'h43: tbl_byte = `DTU_TBL_RSVD;
            8'h44, 8'h45: tbl_byte = `DTU_TBL_RSVD;
            8'h46: tbl_byte = `DTU_TBL_DUAL_WAIT;
            8'h47: tbl_byte = `DTU_TBL_DUAL_OP;
            8'h48, 8'h49: tbl_byte = `DTU_TBL_RSVD;
            8'h4A: tbl_byte = `DTU_TBL_QUAD_WAIT;
            8'h4B: tbl_byte = `DTU_TBL_QUAD_OP;
            8'h4C: tbl_byte = `DTU_TBL_ER1_SIZE;
            8'h4D: tbl_byte = `DTU_TBL_ER1_OP;
            8'h4E: tbl_byte = `DTU_TBL_ER2_SIZE;
            8'h4F: tbl_byte = `DTU_TBL_ER2_OP;
            8'h50: tbl_byte = `DTU_TBL_ER3_SIZE;
            8'h51: tbl_byte = `DTU_TBL_ER3_OP;
            8'h52: tbl_byte = `DTU_TBL_ER4_SIZE;
            8'h53: tbl_byte = `DTU_TBL_ER4_OP;
            // Bytes outside the modelled range read as reserved ones
            default: tbl_byte = `DTU_TBL_RSVD;
        endcase
    end

    // Identifier bytes go out most significant first from 80h
    assign uid_idx = 4'(addr_q - `DTU_UID_BASE);
    always_comb begin
        uid_byte = 8'h00;
        if (addr_q >= `DTU_UID_BASE && addr_q <= `DTU_UID_LAST) begin
            uid_byte = DIE_ID[8'(95 - 8 * uid_idx) -: 8];
        end
    end

    always_comb begin
        unique case (src_q)
            DTU_SRC_TABLE: data_byte = tbl_byte;
            DTU_SRC_UID: data_byte = uid_byte;
            DTU_SRC_STATUS: data_byte = `DTU_STATUS_RESET;
            DTU_SRC_ARRAY: data_byte = `DTU_ERASED_BYTE;
        endcase
    end

    // Command, address and dummy framing on rising edges
    always_ff @(posedge core_clk) begin
        if (reset || sync2_q.cs_n) begin
            state_q <= DTU_IDLE;
            bitcnt_q <= '0;
            shift_in_q <= '0;
            addr_bytes_q <= '0;
        end else begin
            if (state_q == DTU_IDLE) begin
                state_q <= pu_done ? DTU_CMD : DTU_IGNORE;
            end
            if (rise && state_q != DTU_IGNORE) begin
                bitcnt_q <= bitcnt_q + 3'd1;
                shift_in_q <= rx_byte;
                if (bitcnt_q == 3'd7) begin
                    unique case (state_q)
                        DTU_CMD: begin
                            if (rx_byte == `DTU_OP_UID ||
                                    rx_byte == `DTU_OP_TABLE_READ ||
                                    rx_byte == `DTU_OP_READ_ARRAY) begin
                                state_q <= DTU_ADDR;
                            end else if (rx_byte ==
                                    `DTU_OP_READ_STATUS) begin
                                state_q <= DTU_DATA;
                            end else begin
                                state_q <= DTU_IGNORE;
                            end
                        end
                        DTU_ADDR: begin
                            addr_bytes_q <= addr_bytes_q + 2'd1;
                            if (addr_bytes_q == 2'd2) begin
                                state_q <= (cmd_q == `DTU_OP_READ_ARRAY) ?
                                    DTU_DATA : DTU_DUMMY;
                            end
                        end
                        DTU_DUMMY: state_q <= DTU_DATA;
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_q <= '0;
            src_q <= DTU_SRC_TABLE;
        end else if (rise && state_q == DTU_CMD && bitcnt_q == 3'd7) begin
            cmd_q <= rx_byte;
            unique case (rx_byte)
                `DTU_OP_UID: src_q <= DTU_SRC_UID;
                `DTU_OP_READ_STATUS: src_q <= DTU_SRC_STATUS;
                `DTU_OP_READ_ARRAY: src_q <= DTU_SRC_ARRAY;
                default: src_q <= DTU_SRC_TABLE;
            endcase
        end
    end

    // Low address byte picks table or identifier location
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_q <= '0;
        end else if (rise && state_q == DTU_ADDR && bitcnt_q == 3'd7) begin
            addr_q <= rx_byte;
        end else if (fall && state_q == DTU_DATA && bitcnt_q == 3'h0) begin
            // Steps on as each byte is loaded, so the next load sees the
            // following address
            addr_q <= addr_q + 8'h01;
        end
    end

    // Output shifts on falling edges; the first bit of each byte is
    // loaded on the fall that follows the last framing or data bit before it.
    always_ff @(posedge core_clk) begin
        if (reset || sync2_q.cs_n) begin
            out_q <= '0;
            miso_o <= 1'b0;
            miso_oe_n <= 1'b1;
        end else if (fall && state_q == DTU_DATA) begin
            miso_oe_n <= 1'b0;
            if (bitcnt_q == 3'd0) begin
                out_q <= {data_byte[6:0], 1'b0};
                miso_o <= data_byte[7];
            end else begin
                out_q <= {out_q[6:0], 1'b0};
                miso_o <= out_q[7];
            end
        end
    end
endmodule

// ===== hdl/dtu_consts.svh
// Constants for the discovery table and unique identifier responder
`ifndef DTU_CONSTS_SVH
`define DTU_CONSTS_SVH
`define DTU_OP_UID 8'h5A
`define DTU_OP_TABLE 8'h5A
`define DTU_OP_TABLE_READ 8'h5B
`define DTU_OP_READ_STATUS 8'h05
`define DTU_OP_READ_ARRAY 8'h03
`define DTU_UID_BASE 8'h80
`define DTU_UID_LAST 8'h8B
`define DTU_TBL_CAPS 8'hFE
`define DTU_TBL_RSVD 8'hFF
`define DTU_TBL_DUAL_WAIT 8'h00
`define DTU_TBL_DUAL_OP 8'hFF
`define DTU_TBL_QUAD_WAIT 8'h44
`define DTU_TBL_QUAD_OP 8'hEB
`define DTU_TBL_ER1_SIZE 8'h0C
`define DTU_TBL_ER1_OP 8'h20
`define DTU_TBL_ER2_SIZE 8'h0F
`define DTU_TBL_ER2_OP 8'h52
`define DTU_TBL_ER3_SIZE 8'h10
`define DTU_TBL_ER3_OP 8'hD8
`define DTU_TBL_ER4_SIZE 8'h00
`define DTU_TBL_ER4_OP 8'hFF
`define DTU_ERASED_BYTE 8'hFF
`define DTU_STATUS_RESET 8'h00
`define DTU_POWERUP_US 100
`define DTU_CLK_MHZ 100
`define DTU_POWERUP_CYC (`DTU_POWERUP_US * `DTU_CLK_MHZ)
`endif

// ===== hdl/dtu_pkg.sv
// Types for the discovery table and unique identifier responder
package dtu_pkg;
    typedef enum logic [2:0] {
        DTU_IDLE, DTU_CMD, DTU_ADDR, DTU_DUMMY, DTU_DATA, DTU_IGNORE
    } dtu_state_e;
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } dtu_link_in_s;
    typedef enum logic [1:0] {
        DTU_SRC_TABLE, DTU_SRC_UID, DTU_SRC_STATUS, DTU_SRC_ARRAY
    } dtu_src_e;
endpackage

// ===== testbench/dtu_responder_asserts.sv
// Port checks for the serial responder
`timescale 1ns/100ps
module dtu_responder_asserts #(
    parameter int POWERUP_CYCLES = 10000
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    input wire logic ready
);
    int cnt_q;
    logic ign_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence sclk_held;
        sclk ##1 sclk;
    endsequence
    // Saturates so a long run cannot wrap it
    always_ff @(posedge core_clk) begin
        if (reset) cnt_q <= 0;
        else if (cnt_q < POWERUP_CYCLES + 4) cnt_q <= cnt_q + 1;
    end
    always_ff @(posedge core_clk) begin
        if (reset || cs_n) ign_q <= 1'b0;
        else if ($fell(cs_n) && !ready) ign_q <= 1'b1;
    end
    AST_RST_QUIET: assert property (disable iff (1'b0)
        reset |=> miso_oe_n && !ready) else $error("not quiet in reset");
    AST_READY_EARLY: assert property (
        cnt_q < POWERUP_CYCLES |-> !ready) else $error("ready too early");
    AST_READY_LATE: assert property (
        cnt_q > POWERUP_CYCLES + 1 |-> ready) else $error("ready too late");
    AST_IGNORE_EARLY: assert property (ign_q |-> miso_oe_n)
        else $error("early frame answered");
    AST_OE_IDLE: assert property (cs_n [*5] |-> miso_oe_n)
        else $error("output enabled while deselected");
    AST_OE_START: assert property ($fell(miso_oe_n) |-> !cs_n && !sclk)
        else $error("output enabled at wrong moment");
    AST_MISO_FALL: assert property (
        $changed(miso_o) && !miso_oe_n |-> !sclk)
        else $error("data changed with clock high");
    AST_MISO_HOLD: assert property (
        sclk_held ##0 !miso_oe_n |-> $stable(miso_o)) else $error("data moved");
endmodule

// ===== testbench/dtu_host_model.sv
// Host serial controller model, mode 0, one byte per call
`timescale 1ns/100ps
module dtu_host_model (
    input wire logic core_clk,
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    localparam int HALF = 8;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    task automatic sel();
        @(negedge core_clk);
        cs_n <= 1'b0;
        repeat (HALF) @(negedge core_clk);
    endtask
    // Never sends the quad-wide opcode on its own accord
    task automatic xfer(input logic [7:0] tx, input logic chk);
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            repeat (HALF) @(negedge core_clk);
            sclk <= 1'b1;
            rx_byte[i] <= miso;
            repeat (HALF) @(negedge core_clk);
            sclk <= 1'b0;
        end
        rx_valid <= chk;
        @(negedge core_clk);
        rx_valid <= 1'b0;
    endtask
    // Released data line shows the inverse so stale bits cannot pass
    task automatic desel();
        repeat (HALF) @(negedge core_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (2 * HALF) @(negedge core_clk);
    endtask
endmodule

// ===== testbench/tb_dtu_responder.sv
// Self-checking bench for the serial responder
`timescale 1ns/100ps
module tb_dtu_responder;
    localparam int PU = 20;
    // Arbitrary identifier value
    localparam logic [95:0] TB_DIE_ID = 96'hA5C30F1E2D3C4B5A69788796;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sclk, cs_n, mosi, miso_o, miso_oe_n, ready, rx_valid, oe_seen;
    logic [7:0] rx_byte;
    logic [7:0] exp_q[$];
    logic [7:0] tbl[20] = '{8'hFE,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
        8'hFF, 8'hFF, 8'h44, 8'hEB, 8'h0C, 8'h20, 8'h0F,
        8'h52, 8'h10, 8'hD8, 8'h00, 8'hFF};
    int err_count = 0;
    int total_checks = 0;
    integer seed = 32'h6E33;
    initial forever #5 core_clk = ~core_clk;
    dtu_responder #(.POWERUP_CYCLES(PU), .DIE_ID(TB_DIE_ID))
    dtu_responder_inst (.core_clk, .reset, .sclk, .cs_n, .mosi, .miso_o,
        .miso_oe_n, .ready);
    dtu_host_model dtu_host_model_inst (.core_clk,
        .miso(miso_oe_n ? 1'bz : miso_o), .sclk, .cs_n, .mosi, .rx_byte,
        .rx_valid);
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] adr,
        input int hdr, input int n, input logic c);
        logic [7:0] hb[4];
        hb = '{8'h00, 8'h00, adr, 8'($random(seed))};
        oe_seen = 1'b0;
        dtu_host_model_inst.sel();
        dtu_host_model_inst.xfer(op, 1'b0);
        for (int i = 0; i < hdr; i++) dtu_host_model_inst.xfer(hb[i], 1'b0);
        for (int i = 0; i < n; i++)
            dtu_host_model_inst.xfer(8'($random(seed)), c);
        dtu_host_model_inst.desel();
    endtask
    always @(posedge core_clk) if (!miso_oe_n) oe_seen <= 1'b1;
    always @(posedge core_clk) if (rx_valid)
        chk("data", exp_q.pop_front(), rx_byte);
    initial begin
        logic [7:0] st;
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        run(8'h5A, 8'h80, 4, 1, 1'b0);
        chk("oe early", 8'h00, {7'h00, oe_seen});
        for (int i = 0; i < 50 && ready !== 1'b1; i++) @(negedge core_clk);
        chk("ready", 8'h01, {7'h00, ready});
        foreach (tbl[i]) exp_q.push_back(tbl[i]);
        run(8'h5B, 8'h40, 4, 20, 1'b1);
        st = 8'h40 + 8'(unsigned'($random(seed)) % 20);
        for (int i = st; i < 8'h54; i++) exp_q.push_back(tbl[i - 8'h40]);
        run(8'h5B, st, 4, 8'h54 - st, 1'b1);
        for (int i = 0; i < 12; i++) exp_q.push_back(TB_DIE_ID[95-8*i -: 8]);
        run(8'h5A, 8'h80, 4, 12, 1'b1);
        exp_q.push_back(8'h00);
        run(8'h05, 8'h00, 0, 1, 1'b1);
        repeat (2) exp_q.push_back(8'hFF);
        run(8'h03, 8'($random(seed)), 3, 2, 1'b1);
        run(8'hEB, 8'h00, 4, 2, 1'b0);
        chk("oe quad", 8'h00, {7'h00, oe_seen});
        chk("pending", 8'h00, 8'(exp_q.size()));
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end
endmodule
bind dtu_responder dtu_responder_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES))
dtu_responder_asserts_inst (.core_clk, .reset, .sclk, .cs_n, .miso_o,
    .miso_oe_n, .ready);
